// ### design/exec_unit.sv
// Execution unit for loads, special-register moves, status set/clear, multiply and OR, reached over AHB-Lite.
// Assumes the data memory answers a read with mem_rdata in the same clock cycle that mem_req.rd is high.
// Operation
// - Byte load: address first plus second source
// - Immediate byte load uses sign-extended immediate
// - Halfword load clears address LSB, zero-fills
// - Word load aligns address, writes whole word
// - Read-special copies selected register in one cycle
// - Exception registers readable only with exceptions
// - Float status readable needs float unit, exceptions
// - Status-clear returns old word, clears bits
// - Status-set returns old word, sets bits
// - Set and clear touch only low fourteen bits
// - Set and clear need status-instruction enable
// - Carry changes at once, other bits later
// - Write-special loads status or float status
// - Write-special never alters pc or exception registers
// - Float status writable only with float unit
// - Multiply keeps low product word, three cycles
// - Immediate multiply uses sign-extended immediate
// - Multiply needs multiplier primitives and enable
// - Register OR of both sources
// - Immediates sign-extend unless prefixed
// - Prefix supplies upper immediate half
// - No interrupt between prefix and its user
// - Immediate OR with first source
`timescale 1ns/10ps
`default_nettype none
module exec_unit #(
	parameter bit status_instr_enable_param = 1'b1,
	parameter bit hw_multiplier_param = 1'b1,
	parameter bit mul_primitives_param = 1'b1,
	parameter bit float_unit_param = 1'b1,
	parameter bit float_exception_param = 1'b1,
	parameter bit exception_enable_param = 1'b1
) (
	input wire logic hclk, // Bus clock, 20 MHz
	input wire logic hresetn, // Asynchronous reset, active low
	input wire logic hsel, // Slave select
	input wire logic [31:0] haddr, // Byte address
	input wire logic [1:0] htrans, // Transfer type
	input wire logic hwrite, // Write when high
	input wire logic [2:0] hsize, // Transfer size
	input wire logic [31:0] hwdata, // Write data
	input wire logic hready, // Bus ready
	output logic [31:0] hrdata, // Read data
	output logic hreadyout, // Slave ready
	output logic hresp, // Always OKAY
	output exec_unit_pkg::mem_req_s mem_req, // Data memory request
	input wire logic [31:0] mem_rdata, // Data returned in the same cycle as the request
	input wire logic irq_req, // Pending interrupt
	output logic irq_accept // Interrupt taken
);
	logic [31:0] hrdata_ff, a_ff, b_ff, result_ff, msw_ff, pend_ff, fsw_ff, esw_ff, eaw_ff, pc_ff;
	logic [15:0] imm_ff, imm_hi_ff;
	logic [7:0] wr_addr_ff;
	logic wr_pend_ff, go_ff, lock_ff, done_ff, invalid_ff, pend_v_ff, irq_accept_ff;
	logic [1:0] mul_cnt_ff;
	logic [31:0] mul_ff;
	exec_unit_pkg::op_e op_ff;
	exec_unit_pkg::sel_e sel_ff;
	exec_unit_pkg::state_e state_ff;
	exec_unit_pkg::mem_req_s mem_req_ff;

	logic addr_phase, busy, cmd_wr, is_imm_op, mul_ok, msw_op, msw_ok, carry_new, mfs_ok;
	logic [31:0] imm_ext, operand_b, ld_addr, msw_view, nxt_msw, spr_view, mul_lo;
	logic [63:0] product;
	logic [31:0] status_word;

	assign addr_phase = hsel && htrans[1] && hready;
	assign busy = go_ff || (state_ff != exec_unit_pkg::ST_IDLE);
	assign cmd_wr = wr_pend_ff && (wr_addr_ff == exec_unit_pkg::OFS_CMD);
	assign is_imm_op = op_ff inside {exec_unit_pkg::OP_ORI, exec_unit_pkg::OP_LOAD_BYTE_ZERO_EXT_IMM, exec_unit_pkg::OP_LOAD_HALF_ZERO_EXT_IMM,
		exec_unit_pkg::OP_LWI, exec_unit_pkg::OP_MULI};
	// A locked prefix supplies the upper half, otherwise the field is sign-extended
	assign imm_ext = lock_ff ? {imm_hi_ff, imm_ff} : {{16{imm_ff[15]}}, imm_ff};
	assign operand_b = is_imm_op ? imm_ext : b_ff;
	assign ld_addr = a_ff + operand_b;
	assign product = {32'h0000_0000, a_ff} * {32'h0000_0000, operand_b};
	assign mul_lo = product[31:0];
	assign mul_ok = hw_multiplier_param && mul_primitives_param;
	assign msw_ok = status_instr_enable_param;
	assign msw_view = pend_v_ff ? pend_ff : msw_ff;
	assign msw_op = go_ff && ((msw_ok && (op_ff == exec_unit_pkg::OP_SCLR || op_ff == exec_unit_pkg::OP_SSET))
		|| (op_ff == exec_unit_pkg::OP_MTS && sel_ff == exec_unit_pkg::SEL_MSW));
	assign status_word = {28'h0000000, lock_ff, invalid_ff, done_ff, busy};

	always_comb begin
		nxt_msw = msw_view;
		case (op_ff)
			exec_unit_pkg::OP_SCLR: nxt_msw = msw_view & ~({16'h0000, imm_ff} & exec_unit_pkg::MSW_ALTERABLE);
			exec_unit_pkg::OP_SSET: nxt_msw = msw_view | ({16'h0000, imm_ff} & exec_unit_pkg::MSW_ALTERABLE);
			exec_unit_pkg::OP_MTS: nxt_msw = a_ff;
			default: nxt_msw = msw_view;
		endcase
	end
	assign carry_new = nxt_msw[exec_unit_pkg::MSW_CARRY];

	always_comb begin
		spr_view = exec_unit_pkg::WORD_RESET;
		mfs_ok = 1'b1;
		case (sel_ff)
			exec_unit_pkg::SEL_PC: spr_view = pc_ff;
			exec_unit_pkg::SEL_MSW: spr_view = msw_view;
			exec_unit_pkg::SEL_EAW: begin
				spr_view = eaw_ff;
				mfs_ok = exception_enable_param;
			end
			exec_unit_pkg::SEL_ESW: begin
				spr_view = esw_ff;
				mfs_ok = exception_enable_param;
			end
			exec_unit_pkg::SEL_FSW: begin
				spr_view = fsw_ff;
				mfs_ok = float_unit_param && float_exception_param;
			end
			default: mfs_ok = 1'b0;
		endcase
	end

	// Bus slave: zero-wait, so hreadyout stays high and reads are prepared at the address phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= 8'h00;
			hrdata_ff <= exec_unit_pkg::WORD_RESET;
		end else begin
			wr_pend_ff <= addr_phase && hwrite;
			wr_addr_ff <= haddr[7:0];
			if (addr_phase && !hwrite) begin
				case (haddr[7:0])
					exec_unit_pkg::OFS_CMD: hrdata_ff <= {25'h0000000, sel_ff, op_ff};
					exec_unit_pkg::OFS_SRC_A: hrdata_ff <= a_ff;
					exec_unit_pkg::OFS_SRC_B: hrdata_ff <= b_ff;
					exec_unit_pkg::OFS_IMM: hrdata_ff <= {16'h0000, imm_ff};
					exec_unit_pkg::OFS_RESULT: hrdata_ff <= result_ff;
					exec_unit_pkg::OFS_STATUS: hrdata_ff <= status_word;
					exec_unit_pkg::OFS_MSW: hrdata_ff <= msw_ff;
					exec_unit_pkg::OFS_FSW: hrdata_ff <= fsw_ff;
					exec_unit_pkg::OFS_ESW: hrdata_ff <= esw_ff;
					exec_unit_pkg::OFS_EAW: hrdata_ff <= eaw_ff;
					exec_unit_pkg::OFS_PC: hrdata_ff <= pc_ff;
					default: hrdata_ff <= exec_unit_pkg::WORD_RESET;
				endcase
			end
		end
	end

	// Operand and software-owned registers; the exception registers and pc are only ever written from the bus
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			a_ff <= exec_unit_pkg::WORD_RESET;
			b_ff <= exec_unit_pkg::WORD_RESET;
			imm_ff <= 16'h0000;
			esw_ff <= exec_unit_pkg::WORD_RESET;
			eaw_ff <= exec_unit_pkg::WORD_RESET;
			pc_ff <= exec_unit_pkg::WORD_RESET;
		end else if (wr_pend_ff && !busy) begin
			case (wr_addr_ff)
				exec_unit_pkg::OFS_SRC_A: a_ff <= hwdata;
				exec_unit_pkg::OFS_SRC_B: b_ff <= hwdata;
				exec_unit_pkg::OFS_IMM: imm_ff <= hwdata[15:0];
				exec_unit_pkg::OFS_ESW: esw_ff <= hwdata;
				exec_unit_pkg::OFS_EAW: eaw_ff <= hwdata;
				exec_unit_pkg::OFS_PC: pc_ff <= hwdata;
				default: ;
			endcase
		end
	end

	// Command capture: refused while an operation is in flight
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			go_ff <= 1'b0;
			op_ff <= exec_unit_pkg::OP_NOP;
			sel_ff <= exec_unit_pkg::SEL_PC;
		end else begin
			go_ff <= cmd_wr && !busy;
			if (cmd_wr && !busy) begin
				op_ff <= exec_unit_pkg::op_e'(hwdata[exec_unit_pkg::CMD_OP_LSB +: 4]);
				sel_ff <= exec_unit_pkg::sel_e'(hwdata[exec_unit_pkg::CMD_SEL_LSB +: 3]);
			end
		end
	end

	// Immediate prefix lock; consumed by whatever operation follows it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lock_ff <= 1'b0;
			imm_hi_ff <= 16'h0000;
		end else if (go_ff) begin
			lock_ff <= (op_ff == exec_unit_pkg::OP_IMMP);
			if (op_ff == exec_unit_pkg::OP_IMMP) begin
				imm_hi_ff <= imm_ff;
			end
		end
	end

	// Interrupts held off while a prefix waits for its user
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_accept_ff <= 1'b0;
		end else begin
			irq_accept_ff <= irq_req && !lock_ff && !(go_ff && op_ff == exec_unit_pkg::OP_IMMP);
		end
	end

	// Status word: carry lands at once, other bits pass through a one-cycle pending stage
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			msw_ff <= exec_unit_pkg::MSW_RESET;
			pend_ff <= exec_unit_pkg::MSW_RESET;
			pend_v_ff <= 1'b0;
		end else begin
			pend_v_ff <= msw_op;
			if (msw_op) begin
				pend_ff <= nxt_msw;
				msw_ff <= msw_view;
				msw_ff[exec_unit_pkg::MSW_CARRY] <= carry_new;
			end else if (pend_v_ff) begin
				msw_ff <= pend_ff;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fsw_ff <= exec_unit_pkg::WORD_RESET;
		end else if (go_ff && op_ff == exec_unit_pkg::OP_MTS && sel_ff == exec_unit_pkg::SEL_FSW
			&& float_unit_param) begin
			fsw_ff <= a_ff;
		end
	end

	// Execution sequencer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_ff <= exec_unit_pkg::ST_IDLE;
			result_ff <= exec_unit_pkg::WORD_RESET;
			mem_req_ff <= '0;
			mul_ff <= exec_unit_pkg::WORD_RESET;
			mul_cnt_ff <= 2'h0;
			done_ff <= 1'b0;
			invalid_ff <= 1'b0;
		end else begin
			mem_req_ff.rd <= 1'b0;
			if (go_ff) begin
				done_ff <= 1'b0;
				invalid_ff <= 1'b0;
			end
			case (state_ff)
				exec_unit_pkg::ST_IDLE: begin
					if (go_ff) begin
						done_ff <= 1'b1;
						case (op_ff)
							exec_unit_pkg::OP_OR, exec_unit_pkg::OP_ORI: result_ff <= a_ff | operand_b;
							exec_unit_pkg::OP_LBU, exec_unit_pkg::OP_LOAD_BYTE_ZERO_EXT_IMM: begin
								mem_req_ff <= '{rd: 1'b1, size: exec_unit_pkg::SZ_BYTE, addr: ld_addr};
								state_ff <= exec_unit_pkg::ST_LOAD;
								done_ff <= 1'b0;
							end
							exec_unit_pkg::OP_LHU, exec_unit_pkg::OP_LOAD_HALF_ZERO_EXT_IMM: begin
								mem_req_ff <= '{rd: 1'b1, size: exec_unit_pkg::SZ_HALF,
									addr: ld_addr & exec_unit_pkg::HALF_ALIGN};
								state_ff <= exec_unit_pkg::ST_LOAD;
								done_ff <= 1'b0;
							end
							exec_unit_pkg::OP_LW, exec_unit_pkg::OP_LWI: begin
								mem_req_ff <= '{rd: 1'b1, size: exec_unit_pkg::SZ_WORD,
									addr: ld_addr & exec_unit_pkg::WORD_ALIGN};
								state_ff <= exec_unit_pkg::ST_LOAD;
								done_ff <= 1'b0;
							end
							exec_unit_pkg::OP_MFS: begin
								if (mfs_ok) begin
									result_ff <= spr_view;
								end else begin
									invalid_ff <= 1'b1;
								end
							end
							exec_unit_pkg::OP_MTS: begin
								if (!(sel_ff == exec_unit_pkg::SEL_MSW || (sel_ff == exec_unit_pkg::SEL_FSW
									&& float_unit_param))) begin
									invalid_ff <= 1'b1;
								end
							end
							exec_unit_pkg::OP_SCLR, exec_unit_pkg::OP_SSET: begin
								if (msw_ok) begin
									result_ff <= msw_view;
								end else begin
									invalid_ff <= 1'b1;
								end
							end
							exec_unit_pkg::OP_MUL, exec_unit_pkg::OP_MULI: begin
								if (mul_ok) begin
									mul_ff <= mul_lo;
									mul_cnt_ff <= exec_unit_pkg::MUL_CYCLES - 2'h1;
									state_ff <= exec_unit_pkg::ST_MUL;
									done_ff <= 1'b0;
								end else begin
									invalid_ff <= 1'b1;
								end
							end
							exec_unit_pkg::OP_IMMP, exec_unit_pkg::OP_NOP: ;
							default: invalid_ff <= 1'b1;
						endcase
					end
				end
				exec_unit_pkg::ST_LOAD: begin
					case (mem_req_ff.size)
						exec_unit_pkg::SZ_BYTE: result_ff <= {24'h000000, mem_rdata[7:0]};
						exec_unit_pkg::SZ_HALF: result_ff <= {16'h0000, mem_rdata[15:0]};
						default: result_ff <= mem_rdata;
					endcase
					done_ff <= 1'b1;
					state_ff <= exec_unit_pkg::ST_IDLE;
				end
				exec_unit_pkg::ST_MUL: begin
					mul_cnt_ff <= mul_cnt_ff - 2'h1;
					if (mul_cnt_ff == 2'h1) begin
						result_ff <= mul_ff;
						done_ff <= 1'b1;
						state_ff <= exec_unit_pkg::ST_IDLE;
					end
				end
				default: state_ff <= exec_unit_pkg::ST_IDLE;
			endcase
		end
	end

	assign hrdata = hrdata_ff;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign mem_req = mem_req_ff;
	assign irq_accept = irq_accept_ff;

	sequence s_go(exec_unit_pkg::op_e o);
		go_ff && op_ff == o;
	endsequence
	sequence s_mul_done;
		!done_ff ##1 done_ff;
	endsequence

	property p_byte_addr;
		@(posedge hclk) disable iff (!hresetn)
		s_go(exec_unit_pkg::OP_LBU) |=> mem_req_ff.rd && mem_req_ff.addr == $past(ld_addr);
	endproperty
	a_byte_addr: assert property (p_byte_addr) else $error("byte load address wrong");
	property p_byte_fill;
		@(posedge hclk) disable iff (!hresetn)
		s_go(exec_unit_pkg::OP_LOAD_BYTE_ZERO_EXT_IMM) |=> ##1 result_ff[31:8] == 24'h000000 && done_ff;
	endproperty
	a_byte_fill: assert property (p_byte_fill) else $error("byte load not zero-filled in two cycles");
	property p_half_align;
		@(posedge hclk) disable iff (!hresetn)
		mem_req_ff.rd && mem_req_ff.size == exec_unit_pkg::SZ_HALF |-> !mem_req_ff.addr[0];
	endproperty
	a_half_align: assert property (p_half_align) else $error("halfword address not aligned");
	property p_word_load;
		@(posedge hclk) disable iff (!hresetn)
		mem_req_ff.rd && mem_req_ff.size == exec_unit_pkg::SZ_WORD |-> mem_req_ff.addr[1:0] == 2'h0
			##1 result_ff == $past(mem_rdata);
	endproperty
	a_word_load: assert property (p_word_load) else $error("word load wrong");
	property p_mfs;
		@(posedge hclk) disable iff (!hresetn)
		s_go(exec_unit_pkg::OP_MFS) && mfs_ok |=> result_ff == $past(spr_view) && done_ff;
	endproperty
	a_mfs: assert property (p_mfs) else $error("read-special not done in one cycle");
	property p_mfs_bad;
		@(posedge hclk) disable iff (!hresetn)
		s_go(exec_unit_pkg::OP_MFS) && !mfs_ok |=> invalid_ff && $stable(result_ff);
	endproperty
	a_mfs_bad: assert property (p_mfs_bad) else $error("exception register read not refused");
	property p_msw_high_kept;
		@(posedge hclk) disable iff (!hresetn)
		s_go(exec_unit_pkg::OP_SSET) ##0 !pend_v_ff |=> ##1 msw_ff[31:14] == $past(msw_ff[31:14], 2);
	endproperty
	a_msw_high_kept: assert property (p_msw_high_kept) else $error("status set touched high bits");
	property p_carry_now;
		@(posedge hclk) disable iff (!hresetn)
		msw_op |=> msw_ff[exec_unit_pkg::MSW_CARRY] == $past(carry_new) ##1 msw_ff == $past(nxt_msw, 2);
	endproperty
	a_carry_now: assert property (p_carry_now) else $error("status word timing wrong");
	property p_mul;
		@(posedge hclk) disable iff (!hresetn)
		s_go(exec_unit_pkg::OP_MUL) && mul_ok |=> !done_ff ##1 s_mul_done
			##0 result_ff == $past(mul_lo, 3);
	endproperty
	a_mul: assert property (p_mul) else $error("multiply result or latency wrong");
	property p_pc_kept;
		@(posedge hclk) disable iff (!hresetn)
		s_go(exec_unit_pkg::OP_MTS) |=> $stable(pc_ff) && $stable(esw_ff) && $stable(eaw_ff);
	endproperty
	a_pc_kept: assert property (p_pc_kept) else $error("write-special altered protected register");
	property p_no_irq;
		@(posedge hclk) disable iff (!hresetn)
		lock_ff |=> !irq_accept_ff;
	endproperty
	a_no_irq: assert property (p_no_irq) else $error("interrupt taken inside prefix pair");
endmodule
`default_nettype wire

// ### design/exec_unit_pkg.sv
// Package for the execution unit: register offsets, field positions, reset values, encodings and carrier structs.
// Assumes a 32-bit AHB-Lite bus and a data memory that returns read data in the same clock cycle as the request.
package exec_unit_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_CMD = 8'h00;
	localparam logic [7:0] OFS_SRC_A = 8'h04;
	localparam logic [7:0] OFS_SRC_B = 8'h08;
	localparam logic [7:0] OFS_IMM = 8'h0c;
	localparam logic [7:0] OFS_RESULT = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_MSW = 8'h18;
	localparam logic [7:0] OFS_FSW = 8'h1c;
	localparam logic [7:0] OFS_ESW = 8'h20;
	localparam logic [7:0] OFS_EAW = 8'h24;
	localparam logic [7:0] OFS_PC = 8'h28;
	// Command field positions
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_SEL_LSB = 4;
	// Status word bit positions
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_INVALID = 2;
	localparam int ST_LOCK = 3;
	// Status-word layout: bit 0 is the MSB, so big-endian bit n is vector bit 31-n
	localparam int MSW_CARRY = 2;
	localparam logic [31:0] MSW_ALTERABLE = 32'h0000_3fff;
	localparam logic [31:0] MSW_RESET = 32'h0000_0000;
	localparam logic [31:0] WORD_RESET = 32'h0000_0000;
	// Cycle count and address alignment masks
	localparam logic [1:0] MUL_CYCLES = 2'h3;
	localparam logic [31:0] HALF_ALIGN = 32'hffff_fffe;
	localparam logic [31:0] WORD_ALIGN = 32'hffff_fffc;

	typedef enum logic [3:0] {
		OP_OR = 4'h0, OP_ORI = 4'h1, OP_LBU = 4'h2, OP_LOAD_BYTE_ZERO_EXT_IMM = 4'h3,
		OP_LHU = 4'h4, OP_LOAD_HALF_ZERO_EXT_IMM = 4'h5, OP_LW = 4'h6, OP_LWI = 4'h7,
		OP_MFS = 4'h8, OP_MTS = 4'h9, OP_SCLR = 4'ha, OP_SSET = 4'hb,
		OP_MUL = 4'hc, OP_MULI = 4'hd, OP_IMMP = 4'he, OP_NOP = 4'hf
	} op_e;

	typedef enum logic [2:0] {
		SEL_PC = 3'h0, SEL_MSW = 3'h1, SEL_EAW = 3'h2, SEL_ESW = 3'h3, SEL_FSW = 3'h4
	} sel_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0, ST_LOAD = 2'h1, ST_MUL = 2'h2
	} state_e;

	typedef enum logic [1:0] {
		SZ_BYTE = 2'h0, SZ_HALF = 2'h1, SZ_WORD = 2'h2
	} size_e;

	typedef struct packed {
		logic rd;
		size_e size;
		logic [31:0] addr;
	} mem_req_s;
endpackage

// ### testbench/mem_model.sv
// Data memory stand-in for the execution unit's load port.
// Assumes the request comes from a register and holds for its cycle; the answer is read in that cycle.
`timescale 1ns/10ps
`default_nettype none
module mem_model (
	input wire logic hclk, // Clock
	input wire logic hresetn, // Reset, active low
	input wire exec_unit_pkg::mem_req_s mem_req, // Read request
	output logic [31:0] mem_rdata // Read data
);
	logic [31:0] noise_ff;
	// Upper bits are never zero, so a missing zero fill shows up
	function automatic logic [31:0] word_at(input logic [31:0] a);
		return {~a[15:0], a[15:0]} ^ 32'h3c5a_96e1;
	endfunction
	// Idle data changes every cycle so a sample taken at the wrong edge cannot match by luck
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			noise_ff <= 32'h0000_0000;
		end else begin
			noise_ff <= ~noise_ff ^ 32'h0f0f_0000;
		end
	end
	assign mem_rdata = mem_req.rd ? word_at(mem_req.addr) : noise_ff;
endmodule
`default_nettype wire

// ### testbench/test_load_spr_mul_or_exec.sv
// Self-checking bench for the execution unit: AHB-Lite master, command runs, queued result checks.
// Assumes a zero-wait slave and the memory stand-in answering within the request cycle.
`timescale 1ns/10ps
`default_nettype none
module test_load_spr_mul_or_exec;
	logic hclk, hresetn, hsel, hwrite, irq_req, hreadyout, hresp, irq_accept;
	logic [31:0] haddr, hwdata, hrdata, mem_rdata, seen, rnd, a, b, m, st;
	logic [31:0] sp[5];
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [15:0] i16;
	wire logic hready;
	exec_unit_pkg::mem_req_s mem_req;
	logic [31:0] exp_q[$];
	int n_errors = 0, n_tests = 0, cyc = 0, n, op, s;
	event res_ev;
	assign hready = hreadyout;
	exec_unit i_exec_unit (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .mem_req(mem_req), .mem_rdata(mem_rdata), .irq_req(irq_req), .irq_accept(irq_accept));
	mem_model i_mem_model (.hclk(hclk), .hresetn(hresetn), .mem_req(mem_req), .mem_rdata(mem_rdata));
	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function automatic logic [31:0] mem_word(input logic [31:0] v);
		return {~v[15:0], v[15:0]} ^ 32'h3c5a_96e1;
	endfunction
	function automatic logic [31:0] sext(input logic [15:0] v);
		return {{16{v[15]}}, v};
	endfunction
	function automatic logic [31:0] load_exp(input logic [3:0] c, input logic [31:0] x, y, input logic [15:0] i);
		logic [31:0] ad;
		ad = x + (c[0] ? sext(i) : y);
		return c[2:1] == 2'h1 ? mem_word(ad) & 32'h0000_00ff :
			c[2:1] == 2'h2 ? mem_word(ad & exec_unit_pkg::HALF_ALIGN) & 32'h0000_ffff :
			mem_word(ad & exec_unit_pkg::WORD_ALIGN);
	endfunction
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] want);
		n_tests++;
		if (got !== want) begin
			n_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, want);
		end
	endtask
	initial forever begin
		@(res_ev);
		check(seen, exp_q.pop_front());
	end
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			summarize();
		end
	end
	// One single word transfer; a hang here is cut by the cycle ceiling
	task automatic ahb(input logic w, input logic [7:0] o, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, o};
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task automatic wr(input logic [7:0] o, input logic [31:0] d);
		logic [31:0] x;
		ahb(1'b1, o, d, x);
	endtask
	task automatic rd_chk(input logic [7:0] o, input logic [31:0] e);
		logic [31:0] x;
		exp_q.push_back(e);
		ahb(1'b0, o, 32'h0, x);
		seen = x;
		->res_ev;
	endtask
	task automatic note(input logic [31:0] v, input logic [31:0] e);
		@(negedge hclk);
		exp_q.push_back(e);
		seen = v;
		->res_ev;
	endtask
	task automatic run(input logic [3:0] c, input logic [2:0] sel, input logic [31:0] x, y, input logic [15:0] i);
		wr(exec_unit_pkg::OFS_SRC_A, x);
		wr(exec_unit_pkg::OFS_SRC_B, y);
		wr(exec_unit_pkg::OFS_IMM, {16'h0, i});
		wr(exec_unit_pkg::OFS_CMD, {25'h0, sel, c});
		st = 32'h0;
		for (int k = 0; k < 20 && st[exec_unit_pkg::ST_DONE] !== 1'b1; k++) begin
			ahb(1'b0, exec_unit_pkg::OFS_STATUS, 32'h0, st);
		end
	endtask
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		htrans = 2'h0;
		hsize = 3'h2;
		haddr = 32'h0;
		hwdata = 32'h0;
		irq_req = 1'b0;
		rnd = 32'h0000_002f;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		rd_chk(exec_unit_pkg::OFS_MSW, exec_unit_pkg::MSW_RESET);
		rd_chk(8'h40, 32'h0);
		wr(exec_unit_pkg::OFS_MSW, 32'hffff_ffff);
		rd_chk(exec_unit_pkg::OFS_MSW, exec_unit_pkg::MSW_RESET);
		for (n = 0; n < 3; n++) begin
			rnd = lfsr(rnd);
			a = rnd;
			rnd = lfsr(rnd);
			b = rnd;
			i16 = {n[0], rnd[20:6]};
			run(exec_unit_pkg::OP_OR, 3'h0, a, b, i16);
			rd_chk(exec_unit_pkg::OFS_RESULT, a | b);
			run(exec_unit_pkg::OP_ORI, 3'h0, a, b, i16);
			rd_chk(exec_unit_pkg::OFS_RESULT, a | sext(i16));
			run(exec_unit_pkg::OP_MUL, 3'h0, a, b, i16);
			rd_chk(exec_unit_pkg::OFS_RESULT, a * b);
			run(exec_unit_pkg::OP_MULI, 3'h0, a, b, i16);
			rd_chk(exec_unit_pkg::OFS_RESULT, a * sext(i16));
			for (op = 2; op < 8; op++) begin
				run(op[3:0], 3'h0, a, b, i16);
				rd_chk(exec_unit_pkg::OFS_RESULT, load_exp(op[3:0], a, b, i16));
			end
			run(exec_unit_pkg::OP_MTS, exec_unit_pkg::SEL_MSW, a, b, i16);
			rd_chk(exec_unit_pkg::OFS_MSW, a);
			m = {18'h0, rnd[13:0]};
			run(exec_unit_pkg::OP_SCLR, 3'h0, a, b, m[15:0]);
			rd_chk(exec_unit_pkg::OFS_RESULT, a);
			rd_chk(exec_unit_pkg::OFS_MSW, a & ~m);
			run(exec_unit_pkg::OP_SSET, 3'h0, a, b, b[15:0] & 16'h3fff);
			rd_chk(exec_unit_pkg::OFS_RESULT, a & ~m);
			rd_chk(exec_unit_pkg::OFS_MSW, (a & ~m) | (b & 32'h0000_3fff));
			wr(exec_unit_pkg::OFS_PC, b);
			wr(exec_unit_pkg::OFS_ESW, ~a);
			wr(exec_unit_pkg::OFS_EAW, ~b);
			// Moves into pc and the exception words must be dropped; float status takes the value
			for (s = 0; s < 5; s++) begin
				if (s != 1) begin
					run(exec_unit_pkg::OP_MTS, s[2:0], a ^ 32'h5555_5555, b, i16);
					note({31'h0, st[exec_unit_pkg::ST_INVALID]}, {31'h0, s != 4});
				end
			end
			sp = '{b, (a & ~m) | (b & 32'h0000_3fff), ~b, ~a, a ^ 32'h5555_5555};
			for (s = 0; s < 5; s++) begin
				run(exec_unit_pkg::OP_MFS, s[2:0], a, b, i16);
				rd_chk(exec_unit_pkg::OFS_RESULT, sp[s]);
			end
			// An unknown selector is refused and must leave the result alone
			run(exec_unit_pkg::OP_MFS, 3'h5, a, b, i16);
			note({31'h0, st[exec_unit_pkg::ST_INVALID]}, 32'h1);
			rd_chk(exec_unit_pkg::OFS_RESULT, a ^ 32'h5555_5555);
			irq_req <= 1'b1;
			run(exec_unit_pkg::OP_IMMP, 3'h0, a, b, b[31:16]);
			note({31'h0, irq_accept}, 32'h0);
			run(exec_unit_pkg::OP_ORI, 3'h0, a, b, i16);
			note({31'h0, irq_accept}, 32'h1);
			rd_chk(exec_unit_pkg::OFS_RESULT, a | {b[31:16], i16});
			irq_req <= 1'b0;
		end
		#1;
		summarize();
	end
endmodule
`default_nettype wire
